// File: spi_master_model.sv
// Behavioural external SPI master driving the port's slave pins
`timescale 1ns/1ps
module spi_master_model (
    input  wire logic clk,
    output logic      sck,
    output logic      sdi,
    output logic      ss_n
);
    localparam int H = 4;

    // ========
    // Idle: clock still at level 0, deselected
    initial begin
        sck = 1'b0;
        sdi = 1'b0;
        ss_n = 1'b1;
    end

    // Data leads the rising edge by H clocks, a third of the bit time, so either sampling
    // edge sees it; released data shows the inverse, not a held value
    task automatic xfer(input logic [7:0] d, input int nb, input logic sel);
        @(posedge clk);
        ss_n <= ~sel;
        for (int i = 0; i < nb; i++) begin
            repeat (H) @(posedge clk);
            sdi <= d[7 - i];
            repeat (H) @(posedge clk);
            sck <= 1'b1;
            repeat (H) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (H) @(posedge clk);
        ss_n <= 1'b1;
        sdi <= ~sdi;
    endtask
endmodule

// File: sync_serial_defines.svh
// Register offsets, field positions, mode codes and timing counts
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH

// ==========================================================
// Register offsets
`define OFS_CTRL1      3'h0
`define OFS_STATUS     3'h1
`define OFS_BUF        3'h2
`define OFS_ADDR       3'h3
`define OFS_CTRL2      3'h4

// ==========================================================
// Control register one fields
`define C1_WCOL        7
`define C1_OVF         6
`define C1_ON          5
`define C1_IDLE_LVL    4

// ==========================================================
// Status register fields
`define ST_SLEW        7
`define ST_CKE         6
`define ST_DA          5
`define ST_STOP        4
`define ST_START       3
`define ST_RW          2
`define ST_RELOAD      1
`define ST_FULL        0

// ==========================================================
// Reset values
`define CTRL1_RST      8'h00
`define STATUS_RST     8'h00
`define ADDR_RST       8'h00
`define MASK_RST       8'hFF

// ==========================================================
// Mode select codes
`define M_DIV4         4'h0
`define M_DIV16        4'h1
`define M_DIV64        4'h2
`define M_TMR          4'h3
`define M_SLV_SS       4'h4
`define M_SLV_NOSS     4'h5
`define M_DIV8         4'hA
`define M_MASK_ACC     4'h9
`define M_TW_MASTER    4'h8

// ==========================================================
// Master half-period lengths in clk cycles, last edge and last bit counts
`define HALF_DIV4      6'h02
`define HALF_DIV8      6'h04
`define HALF_DIV16     6'h08
`define HALF_DIV64     6'h20
`define LAST_EDGE      4'hF
`define LAST_BIT       3'h7

`endif

// File: sync_serial_pkg.sv
// Types shared by the serial port and its surroundings
package sync_serial_pkg;

    // ==========================================================
    // Master sequencer states
    typedef enum logic [0:0] {
        MST_IDLE = 1'b0,
        MST_RUN  = 1'b1
    } mst_state_e;

    // ==========================================================
    // SPI pin inputs
    typedef struct packed {
        logic sck;
        logic sdi;
        logic ss_n;
        logic sdo_is_input;
    } spi_pins_s;

    // ==========================================================
    // Events reported by the two-wire bus engine
    typedef struct packed {
        logic       start_seen;
        logic       stop_seen;
        logic       addr_match;
        logic       addr_rw;
        logic       nack;
        logic       rx_done;
        logic [7:0] rx_byte;
        logic       byte_is_data;
        logic       tx_done;
        logic       reload_req;
    } twi_evt_s;

    // ==========================================================
    // Configuration handed to the two-wire bus engine
    typedef struct packed {
        logic [6:0] baud_reload;
        logic [7:0] own_addr;
        logic [6:0] addr_mask;
        logic       slew_ctl_off;
        logic       smbus_inputs;
        logic       active;
        logic [4:0] go_bits;
    } twi_cfg_s;

endpackage

// File: sync_serial_port.sv
// Combined SPI / two-wire serial port: registers, SPI shifter, status
`timescale 1ns/1ps
`include "sync_serial_defines.svh"

module sync_serial_port (
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic [2:0]            addr,
    input  wire logic [7:0]            wr_data,
    input  wire logic                  wr_en,
    input  wire logic                  rd_en,
    output logic      [7:0]            rd_data,
    input  wire sync_serial_pkg::spi_pins_s pins_i,
    input  wire logic                  sleep_i,
    input  wire logic                  tmr_tick_i,
    input  wire logic                  irq_en_i,
    input  wire sync_serial_pkg::twi_evt_s  twi_evt_i,
    output logic                       sck_o,
    output logic                       sck_oe,
    output logic                       sdo_o,
    output logic                       sdo_oe,
    output logic                       irq_pulse,
    output logic                       wake_o,
    output logic      [7:0]            tx_byte,
    output sync_serial_pkg::twi_cfg_s  twi_cfg_o
);

    // ==========================================================
    // State
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] stat_q, stat_d;
    logic [7:0] buf_q, buf_d;
    logic [7:0] sr_q, sr_d;
    logic [7:0] adr_q, adr_d;
    logic [7:0] msk_q, msk_d;
    logic [4:0] go_q, go_d;
    logic [2:0] bit_q, bit_d;
    logic [3:0] edg_q, edg_d;
    logic [5:0] div_q, div_d;
    logic       mlvl_q, mlvl_d;
    logic       slvl_q, slvl_d;
    logic       out_q, out_d;
    logic       sck_q, sck_d;
    logic       scke_q, scke_d;
    logic       sdoe_q, sdoe_d;
    logic       irq_q, irq_d;
    logic       wake_q, wake_d;
    logic       act_q, act_d;
    logic [7:0] rd_q, rd_d;
    sync_serial_pkg::mst_state_e mst_q, mst_d;

    // ==========================================================
    // Decoded modes
    logic [3:0] mode;
    logic       on, idle_lvl, cke, master, slave, spi, lvl_now;
    logic       slave_en, lead, trail, sample, shift, done, tick;
    logic [5:0] half;

    assign mode   = ctrl1_q[3:0];
    assign on     = ctrl1_q[`C1_ON];
    assign idle_lvl = ctrl1_q[`C1_IDLE_LVL];
    assign cke    = stat_q[`ST_CKE];
    assign master = (mode == `M_DIV4) || (mode == `M_DIV16) ||
                    (mode == `M_DIV64) || (mode == `M_TMR) ||
                    (mode == `M_DIV8);
    assign slave  = (mode == `M_SLV_SS) || (mode == `M_SLV_NOSS);
    assign spi    = master || slave;

    // Slave shifting gate; mode 0101 ignores SS entirely
    assign slave_en = on && ((mode == `M_SLV_NOSS) ||
                      ((mode == `M_SLV_SS) && !pins_i.ss_n));

    // Half period of the generated clock per divider setting
    always_comb begin
        if (mode == `M_DIV16) begin
            half = `HALF_DIV16;
        end else if (mode == `M_DIV64) begin
            half = `HALF_DIV64;
        end else if (mode == `M_DIV8) begin
            half = `HALF_DIV8;
        end else begin
            half = `HALF_DIV4;
        end
    end

    // ==========================================================
    // Next-state logic for the whole port
    always_comb begin
        ctrl1_d = ctrl1_q;
        stat_d  = stat_q;
        buf_d   = buf_q;
        sr_d    = sr_q;
        adr_d   = adr_q;
        msk_d   = msk_q;
        go_d    = go_q;
        bit_d   = bit_q;
        edg_d   = edg_q;
        div_d   = div_q;
        mlvl_d  = mlvl_q;
        out_d   = out_q;
        mst_d   = mst_q;
        irq_d   = 1'b0;
        rd_d    = 8'h00;
        lead    = 1'b0;
        trail   = 1'b0;
        tick    = 1'b0;
        done    = 1'b0;
        // Pin clock is sampled; the shifter runs on its edges
        lvl_now = pins_i.sck ^ idle_lvl;
        slvl_d  = lvl_now;
        if (slave_en && slave) begin
            lead  = lvl_now && !slvl_q;
            trail = !lvl_now && slvl_q;
        end

        // Master clock generation, frozen while asleep
        if (master && mst_q == sync_serial_pkg::MST_RUN &&
            !sleep_i) begin
            tick = (mode == `M_TMR) ? tmr_tick_i :
                   (div_q == half - 6'h01);
            if (tick) begin
                div_d  = 6'h00;
                mlvl_d = !mlvl_q;
                lead   = !mlvl_q;
                trail  = mlvl_q;
                edg_d  = edg_q + 4'h1;
                if (edg_q == `LAST_EDGE) begin
                    mst_d = sync_serial_pkg::MST_IDLE;
                end
            end else if (mode != `M_TMR) begin
                div_d = div_q + 6'h01;
            end
        end

        // Edge select 1 samples on the leading edge (modes 0,0 and 1,0)
        sample = cke ? lead : trail;
        shift  = cke ? trail : lead;
        if (spi && sample) begin
            sr_d = {sr_q[6:0], pins_i.sdi};
            if (bit_q == `LAST_BIT) begin
                bit_d = 3'h0;
                done  = 1'b1;
            end else begin
                bit_d = bit_q + 3'h1;
            end
        end
        if (spi && shift) begin
            out_d = sr_q[7];
        end

        // SS high in mode 0100 abandons the partial byte
        if (mode == `M_SLV_SS && pins_i.ss_n) begin
            bit_d = 3'h0;
        end

        // Register reads; a buffer read empties the buffer
        if (rd_en) begin
            if (addr == `OFS_CTRL1) begin
                rd_d = ctrl1_q;
            end else if (addr == `OFS_STATUS) begin
                rd_d = stat_q;
            end else if (addr == `OFS_BUF) begin
                rd_d = buf_q;
                stat_d[`ST_FULL] = 1'b0;
            end else if (addr == `OFS_ADDR) begin
                rd_d = (mode == `M_MASK_ACC) ? msk_q : adr_q;
            end else if (addr == `OFS_CTRL2) begin
                rd_d = {3'h0, go_q};
            end else begin
                rd_d = 8'h00;
            end
        end

        // Register writes
        if (wr_en) begin
            if (addr == `OFS_CTRL1) begin
                ctrl1_d = wr_data;
            end else if (addr == `OFS_STATUS) begin
                stat_d[7:6] = wr_data[7:6];
            end else if (addr == `OFS_BUF) begin
                if (spi && (mst_q == sync_serial_pkg::MST_RUN ||
                    (slave && bit_q != 3'h0))) begin
                    ctrl1_d[`C1_WCOL] = 1'b1;
                end else begin
                    buf_d = wr_data;
                    sr_d  = wr_data;
                    out_d = wr_data[7];
                    if (!spi) begin
                        stat_d[`ST_FULL] = 1'b1;
                    end
                    if (mode == `M_TW_MASTER) begin
                        stat_d[`ST_RW] = 1'b1;
                    end
                    if (master) begin
                        mst_d  = sync_serial_pkg::MST_RUN;
                        div_d  = 6'h00;
                        edg_d  = 4'h0;
                        mlvl_d = 1'b0;
                    end
                end
            end else if (addr == `OFS_ADDR) begin
                if (mode == `M_MASK_ACC) begin
                    msk_d = wr_data;
                end else begin
                    adr_d = wr_data;
                    stat_d[`ST_RELOAD] = 1'b0;
                end
            end else if (addr == `OFS_CTRL2) begin
                go_d = wr_data[4:0];
            end
        end

        // SPI byte complete; overflow keeps the unread byte
        if (done) begin
            irq_d = 1'b1;
            if (stat_q[`ST_FULL] && slave) begin
                ctrl1_d[`C1_OVF] = 1'b1;
            end else begin
                buf_d = sr_d;
                stat_d[`ST_FULL] = 1'b1;
            end
        end

        // Two-wire engine events; they win over register reads and writes in the same cycle
        if (on && !spi) begin
            if (twi_evt_i.rx_done) begin
                if (stat_q[`ST_FULL]) begin
                    ctrl1_d[`C1_OVF] = 1'b1;
                end else begin
                    buf_d = twi_evt_i.rx_byte;
                end
                stat_d[`ST_FULL] = 1'b1;
                irq_d = 1'b1;
            end
            if (twi_evt_i.tx_done) begin
                stat_d[`ST_FULL] = 1'b0;
                irq_d = 1'b1;
                if (mode == `M_TW_MASTER) begin
                    stat_d[`ST_RW] = 1'b0;
                end
            end
            if (twi_evt_i.rx_done || twi_evt_i.tx_done) begin
                stat_d[`ST_DA] = twi_evt_i.byte_is_data;
            end
            if (twi_evt_i.addr_match) begin
                stat_d[`ST_DA] = 1'b0;
                stat_d[`ST_RW] = twi_evt_i.addr_rw;
            end
            if (mode != `M_TW_MASTER && (twi_evt_i.start_seen ||
                twi_evt_i.stop_seen || twi_evt_i.nack)) begin
                stat_d[`ST_RW] = 1'b0;
            end
            if (twi_evt_i.start_seen) begin
                stat_d[`ST_START] = 1'b1;
                stat_d[`ST_STOP]  = 1'b0;
            end
            if (twi_evt_i.stop_seen) begin
                stat_d[`ST_STOP]  = 1'b1;
                stat_d[`ST_START] = 1'b0;
            end
            if (twi_evt_i.reload_req) begin
                stat_d[`ST_RELOAD] = 1'b1;
            end
        end

        // Port off: shifter idle, bus flags cleared
        if (!on) begin
            bit_d = 3'h0;
            mst_d = sync_serial_pkg::MST_IDLE;
            mlvl_d = 1'b0;
            stat_d[5:1] = 5'h00;
            go_d = 5'h00;
        end
    end

    // ==========================================================
    // Pin and flag outputs; in mode 0100 SDO released one clock after SS rises
    always_comb begin
        sck_d  = (master && mst_q == sync_serial_pkg::MST_RUN) ?
                 (mlvl_d ^ idle_lvl) : idle_lvl;
        scke_d = on && master;
        sdoe_d = on && !pins_i.sdo_is_input &&
                 (master || (slave && slave_en));
        wake_d = irq_d && irq_en_i && sleep_i;
        act_d  = on && !spi && (stat_d[`ST_RW] || (|go_d));
    end

    // ==========================================================
    // Registers; device reset disables the port and aborts transfers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl1_q <= `CTRL1_RST;
            stat_q  <= `STATUS_RST;
            buf_q   <= 8'h00;
            sr_q    <= 8'h00;
            adr_q   <= `ADDR_RST;
            msk_q   <= `MASK_RST;
            go_q    <= 5'h00;
            bit_q   <= 3'h0;
            edg_q   <= 4'h0;
            div_q   <= 6'h00;
            mlvl_q  <= 1'b0;
            slvl_q  <= 1'b0;
            out_q   <= 1'b0;
            sck_q   <= 1'b0;
            scke_q  <= 1'b0;
            sdoe_q  <= 1'b0;
            irq_q   <= 1'b0;
            wake_q  <= 1'b0;
            act_q   <= 1'b0;
            rd_q    <= 8'h00;
            mst_q   <= sync_serial_pkg::MST_IDLE;
        end else begin
            ctrl1_q <= ctrl1_d;
            stat_q  <= stat_d;
            buf_q   <= buf_d;
            sr_q    <= sr_d;
            adr_q   <= adr_d;
            msk_q   <= msk_d;
            go_q    <= go_d;
            bit_q   <= bit_d;
            edg_q   <= edg_d;
            div_q   <= div_d;
            mlvl_q  <= mlvl_d;
            slvl_q  <= slvl_d;
            out_q   <= out_d;
            sck_q   <= sck_d;
            scke_q  <= scke_d;
            sdoe_q  <= sdoe_d;
            irq_q   <= irq_d;
            wake_q  <= wake_d;
            act_q   <= act_d;
            rd_q    <= rd_d;
            mst_q   <= mst_d;
        end
    end

    // ==========================================================
    // Output wiring, all straight from flip-flops
    assign rd_data   = rd_q;
    assign sck_o     = sck_q;
    assign sck_oe    = scke_q;
    assign sdo_o     = out_q;
    assign sdo_oe    = sdoe_q;
    assign irq_pulse = irq_q;
    assign wake_o    = wake_q;
    assign tx_byte   = sr_q;
    assign twi_cfg_o.baud_reload  = adr_q[6:0];
    assign twi_cfg_o.own_addr     = adr_q;
    assign twi_cfg_o.addr_mask    = msk_q[6:0];
    assign twi_cfg_o.slew_ctl_off = stat_q[`ST_SLEW];
    assign twi_cfg_o.smbus_inputs = stat_q[`ST_CKE];
    assign twi_cfg_o.active       = act_q;
    assign twi_cfg_o.go_bits      = go_q;

endmodule

// File: sync_serial_port_chk.sv
// Port-level checker for the serial port, bound to its top module
`timescale 1ns/1ps
module sync_serial_port_chk (
    input wire logic                       clk,
    input wire logic                       sys_rst,
    input wire logic [2:0]                 addr,
    input wire logic [7:0]                 wr_data,
    input wire logic                       wr_en,
    input wire sync_serial_pkg::spi_pins_s pins_i,
    input wire logic                       sleep_i,
    input wire logic                       irq_en_i,
    input wire sync_serial_pkg::twi_evt_s  twi_evt_i,
    input wire logic                       sck_o,
    input wire logic                       sdo_oe,
    input wire logic                       irq_pulse,
    input wire logic                       wake_o,
    input wire logic [7:0]                 tx_byte,
    input wire sync_serial_pkg::twi_cfg_s  twi_cfg_o
);
    // ========
    // Shadow of control one; hardware only sets its top two flag bits
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    always_comb begin
        ctl_d = ctl_q;
        if (wr_en && addr == 3'h0) ctl_d = wr_data;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) ctl_q <= 8'h00;
        else ctl_q <= ctl_d;
    end
    wire ss_mode = ctl_q[5] && ctl_q[3:0] == 4'h4;
    wire tw = ctl_q[5] && ctl_q[3:0] > 4'h5 && ctl_q[3:0] != 4'hA;

    // ========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_ss_drive: assert property (
        ss_mode && !pins_i.ss_n && !pins_i.sdo_is_input |=> sdo_oe)
        else $error("sdo not driven while selected");
    a_ss_release: assert property (
        ss_mode && pins_i.ss_n |=> !sdo_oe)
        else $error("sdo still driven after deselect");
    a_sdo_input: assert property (
        pins_i.sdo_is_input |=> !sdo_oe)
        else $error("sdo driven while set as input");
    a_sleep_hold: assert property (
        sleep_i |=> $stable(sck_o))
        else $error("serial clock moved during sleep");
    a_wake_cause: assert property (
        wake_o |-> irq_pulse && $past(sleep_i && irq_en_i))
        else $error("wake without its cause");
    a_reset_quiet: assert property (
        $fell(sys_rst) |-> !sdo_oe && !irq_pulse &&
            twi_cfg_o.addr_mask == 7'h7F)
        else $error("outputs not quiet after reset");
    a_rx_flag: assert property (
        tw && twi_evt_i.rx_done |=> irq_pulse)
        else $error("no flag for received byte");
    a_tx_load: assert property (
        tw && wr_en && addr == 3'h2 |=> tx_byte == $past(wr_data))
        else $error("buffer write missed shift register");
    a_baud_load: assert property (
        wr_en && addr == 3'h3 && ctl_q[3:0] != 4'h9 |-> ##2
            twi_cfg_o.baud_reload == $past(wr_data[6:0], 2))
        else $error("reload value not taken");
    a_go_active: assert property (
        tw && ctl_q[3:0] == 4'h8 && wr_en && addr == 3'h4 &&
            wr_data[4:0] != 5'h00 |-> ##2 twi_cfg_o.active)
        else $error("go bit did not show active");
endmodule

bind sync_serial_port sync_serial_port_chk chk_i (.*);

// File: sync_serial_port_select_status_test.sv
// Self-checking bench for the serial port select and status block
`timescale 1ns/1ps
module sync_serial_port_select_status_test;
    logic                       clk = 1'b0;
    logic                       sys_rst = 1'b1;
    logic [2:0]                 addr = 3'h0;
    logic [7:0]                 wr_data = 8'h00;
    logic                       wr_en = 1'b0;
    logic                       rd_en = 1'b0;
    logic [7:0]                 rd_data;
    sync_serial_pkg::spi_pins_s pins_i;
    logic                       sleep_i = 1'b0;
    logic                       tmr_tick_i = 1'b0;
    logic                       irq_en_i = 1'b0;
    sync_serial_pkg::twi_evt_s  twi_evt_i = '0;
    logic                       sck_o, sck_oe, sdo_o, sdo_oe;
    logic                       irq_pulse, wake_o;
    logic [7:0]                 tx_byte;
    sync_serial_pkg::twi_cfg_s  twi_cfg_o;
    logic                       m_sck, m_sdi, m_ss_n;
    logic                       sdo_in = 1'b0;
    int                         bad_count = 0;
    int                         n_tests = 0;
    int                         irq_n = 0;
    int                         wake_n = 0;
    int                         k;
    logic [3:0]                 mm [4] = '{4'h0, 4'h1, 4'hA, 4'h3};

    assign pins_i = {m_sck, m_sdi, m_ss_n, sdo_in};
    always #4 clk = ~clk;
    sync_serial_port uut (.*);
    spi_master_model m (.clk(clk), .sck(m_sck), .sdi(m_sdi), .ss_n(m_ss_n));

    // ========
    // Count flag and wake pulses as they leave the port
    always @(posedge clk) begin
        if (irq_pulse === 1'b1) irq_n++;
        if (wake_o === 1'b1) wake_n++;
    end

    // Timer ticks every other clock, feeding the timer-clocked master pass
    always @(posedge clk) tmr_tick_i <= ~tmr_tick_i;

    // ========
    // Bus tasks and comparison
    task automatic chk(input string nm, input logic [7:0] s,
                       input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] msk,
                      input logic [7:0] e, input string nm);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(nm, rd_data & msk, e);
    endtask
    task automatic pulse(input sync_serial_pkg::twi_evt_s e);
        @(posedge clk);
        twi_evt_i <= e;
        @(posedge clk);
        twi_evt_i <= '0;
    endtask
    // Bounded wait for one flag pulse; running out ends the run
    task automatic wait_irq(input int c);
        int t;
        t = 0;
        while (irq_n == c && t < 300) begin
            @(posedge clk);
            t++;
        end
        if (t == 300) begin
            bad_count++;
            results();
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ========
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rd(3'h1, 8'hFF, 8'h00, "status reset");
        wr(3'h1, 8'hFF);
        rd(3'h1, 8'hFF, 8'hC0, "status write");
        wr(3'h1, 8'h00);
        wr(3'h5, 8'hAA);
        rd(3'h5, 8'hFF, 8'h00, "unmapped");
        // Two-wire slave: status follows bus events
        wr(3'h0, 8'h27);
        pulse(17'h10000);
        rd(3'h1, 8'h18, 8'h08, "start seen");
        pulse(17'h08000);
        rd(3'h1, 8'h18, 8'h10, "stop seen");
        k = irq_n;
        pulse(17'h00D3C);
        rd(3'h1, 8'h21, 8'h21, "data byte");
        chk("rx flag", 8'(irq_n - k), 8'h01);
        rd(3'h2, 8'hFF, 8'hA7, "rx byte");
        rd(3'h1, 8'h01, 8'h00, "rx empty");
        pulse(17'h00800);
        rd(3'h1, 8'h21, 8'h01, "addr byte");
        rd(3'h2, 8'hFF, 8'h00, "addr value");
        pulse(17'h06000);
        rd(3'h1, 8'h04, 8'h04, "dir read");
        pulse(17'h01000);
        rd(3'h1, 8'h04, 8'h00, "dir nack");
        pulse(17'h00001);
        rd(3'h1, 8'h02, 8'h02, "reload");
        wr(3'h2, 8'h3C);
        #1;
        chk("tx byte", tx_byte, 8'h3C);
        rd(3'h1, 8'h01, 8'h01, "tx full");
        pulse(17'h00002);
        rd(3'h1, 8'h01, 8'h00, "tx done");
        wr(3'h0, 8'h07);
        rd(3'h1, 8'h18, 8'h00, "port off");
        // Two-wire master: address location and mask sharing
        wr(3'h0, 8'h28);
        wr(3'h3, 8'h55);
        rd(3'h3, 8'hFF, 8'h55, "baud");
        wr(3'h0, 8'h29);
        rd(3'h3, 8'hFF, 8'hFF, "mask reset");
        wr(3'h3, 8'h3C);
        rd(3'h3, 8'hFF, 8'h3C, "mask");
        wr(3'h0, 8'h28);
        rd(3'h3, 8'hFF, 8'h55, "baud kept");
        wr(3'h2, 8'h11);
        rd(3'h1, 8'h04, 8'h04, "master tx");
        // End the transmit so that only the go bit can show activity
        pulse(17'h00002);
        rd(3'h1, 8'h05, 8'h00, "master tx end");
        wr(3'h4, 8'h02);
        repeat (2) @(posedge clk);
        chk("active", 8'(twi_cfg_o.active), 8'h01);
        wr(3'h0, 8'h08);
        repeat (3) @(posedge clk);
        chk("idle", 8'(twi_cfg_o.active), 8'h00);
        // SPI slave with select control; partial byte then full byte
        wr(3'h0, 8'h24);
        wr(3'h1, 8'h40);
        m.xfer(8'hFF, 3, 1'b1);
        sleep_i <= 1'b1;
        irq_en_i <= 1'b1;
        k = irq_n;
        m.xfer(8'hC5, 8, 1'b1);
        repeat (4) @(posedge clk);
        chk("slave flag", 8'(irq_n - k), 8'h01);
        chk("wake", 8'(wake_n), 8'h01);
        sleep_i <= 1'b0;
        rd(3'h2, 8'hFF, 8'hC5, "slave byte");
        // Select ignored, output pin as input, port toggled mid-byte
        wr(3'h1, 8'h00);
        wr(3'h0, 8'h25);
        sdo_in <= 1'b1;
        m.xfer(8'hA0, 3, 1'b0);
        wr(3'h0, 8'h05);
        wr(3'h0, 8'h25);
        m.xfer(8'h5A, 8, 1'b0);
        repeat (4) @(posedge clk);
        rd(3'h2, 8'hFF, 8'h5A, "no select");
        sdo_in <= 1'b0;
        // Master in all four bus modes and four clock sources; one sleeps
        for (int i = 0; i < 4; i++) begin
            wr(3'h0, {3'b001, i[1], mm[i]});
            wr(3'h1, {1'b0, ~i[0], 6'h00});
            repeat (3) @(posedge clk);
            chk("idle level", 8'(sck_o), 8'(i[1]));
            k = irq_n;
            wr(3'h2, 8'hA5);
            #1;
            chk("sdo msb", 8'(sdo_o), 8'h01);
            if (i == 1) begin
                repeat (5) @(posedge clk);
                sleep_i <= 1'b1;
                repeat (20) @(posedge clk);
                sleep_i <= 1'b0;
            end
            wait_irq(k);
            repeat (8) @(posedge clk);
            chk("end level", 8'(sck_o), 8'(i[1]));
        end
        // Reset in mid-transfer
        wr(3'h0, 8'h20);
        wr(3'h2, 8'hA5);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        k = irq_n;
        repeat (60) @(posedge clk);
        chk("aborted", 8'(irq_n - k), 8'h00);
        chk("clock off", 8'(sck_oe), 8'h00);
        rd(3'h0, 8'hFF, 8'h00, "ctrl reset");
        results();
    end
endmodule
